/* File: src/pdt_params.svh */
// timing and field constants for the programmable delay trigger
`ifndef PDT_PARAMS_SVH
`define PDT_PARAMS_SVH

// =====================================================================
// sizes
`define PDT_NUM_CHAN 2
`define PDT_CNT_W 16
`define PDT_PRE_W 8
// =====================================================================
// output-select encodings
`define PDT_OS_BYPASS 2'h0
`define PDT_OS_DELAY 2'h1
// =====================================================================
// latency of the pre-trigger beyond the scaled delay, in bus clocks
`define PDT_PRE_LAT 2
// trigger output follows pre-trigger by this many bus clocks
`define PDT_TRIG_LAT 1
// reset values
`define PDT_CNT_RST 16'h0000
`define PDT_PRE_RST 8'h00

`endif

/* File: src/pdt_pkg.sv */
// types shared by the programmable delay trigger files
package pdt_pkg;
  // per-channel configuration
  typedef struct packed {
    logic slot_a_enable;
    logic slot_b_enable;
    logic [1:0] slot_a_output_select;
    logic [1:0] slot_b_output_select;
    logic [15:0] slot_a_delay_value;
    logic [15:0] slot_b_delay_value;
  } pdt_chan_cfg_t;
  // per-channel converter-facing outputs
  typedef struct packed {
    logic conv_hw_select_a;
    logic conv_hw_select_b;
    logic slot_a_conv_start;
    logic slot_b_conv_start;
  } pdt_chan_out_t;
  // counter run states
  typedef enum logic [1:0] {
    PDT_IDLE = 2'b01,
    PDT_RUN = 2'b10
  } pdt_state_t;
endpackage : pdt_pkg

/* File: src/pdt_sync.sv */
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ns
module pdt_sync (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_async,
  output logic o_sync
);
  logic stage1;
  // =====================================================================
  // first stage feeds only the second
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      stage1 <= 1'b0;
      o_sync <= 1'b0;
    end
    else
    begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule : pdt_sync

/* File: src/pdt_chan.sv */
// one channel: delay compare, ping-pong hold-off and sequence faults
`timescale 1ns/1ns
`include "pdt_params.svh"
module pdt_chan
  import pdt_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_enable,
  input wire logic i_event,
  input wire logic i_running,
  input wire logic i_tick,
  input wire logic [15:0] i_count,
  input pdt_chan_cfg_t i_cfg,
  input wire logic i_conv_done_set_a,
  input wire logic i_conv_done_set_b,
  input wire logic i_clear_fault_a,
  input wire logic i_clear_fault_b,
  output pdt_chan_out_t o_out,
  output logic o_slot_a_sequence_fault,
  output logic o_slot_b_sequence_fault
);
  logic hit_a;
  logic hit_b;
  logic pre_a;
  logic pre_b;
  logic busy_a;
  logic busy_b;
  logic fire_a;
  logic fire_b;
  // =====================================================================
  // delay expiry: compare hit or bypass passes the event straight through
  wire match_a = i_running && i_tick && (i_count == i_cfg.slot_a_delay_value);
  wire match_b = i_running && i_tick && (i_count == i_cfg.slot_b_delay_value);
  // i_tick marks the first clock of a count value, so a hit lands at event + max(prescale, 1)*delay + 1
  wire byp_a = (i_cfg.slot_a_output_select == `PDT_OS_BYPASS) && i_event;
  wire byp_b = (i_cfg.slot_b_output_select == `PDT_OS_BYPASS) && i_event;
  wire dly_a = (i_cfg.slot_a_output_select == `PDT_OS_DELAY) && match_a;
  wire dly_b = (i_cfg.slot_b_output_select == `PDT_OS_DELAY) && match_b;
  wire go_a = i_enable && i_cfg.slot_a_enable && byp_a;
  wire go_b = i_enable && i_cfg.slot_b_enable && byp_b;
  wire now_a = i_enable && i_cfg.slot_a_enable && dly_a;
  wire now_b = i_enable && i_cfg.slot_b_enable && dly_b;
  // hold-off: the other slot's conversion still running
  wire next_fire_a = pre_a && !busy_b;
  wire next_fire_b = pre_b && !busy_a;
  // =====================================================================
  // bypass waits one clock in hit so both paths give pre-trigger at event plus scaled delay plus two, bypass counting as zero delay
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      hit_a <= 1'b0;
      hit_b <= 1'b0;
      pre_a <= 1'b0;
      pre_b <= 1'b0;
      fire_a <= 1'b0;
      fire_b <= 1'b0;
    end
    else
    begin
      hit_a <= go_a;
      hit_b <= go_b;
      pre_a <= (hit_a || now_a) && i_cfg.slot_a_enable;
      pre_b <= (hit_b || now_b) && i_cfg.slot_b_enable;
      fire_a <= next_fire_a && i_cfg.slot_a_enable;
      fire_b <= next_fire_b && i_cfg.slot_b_enable;
    end
  end
  // =====================================================================
  // conversion-in-progress trackers and sticky faults (set beats clear)
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      busy_a <= 1'b0;
      busy_b <= 1'b0;
      o_slot_a_sequence_fault <= 1'b0;
      o_slot_b_sequence_fault <= 1'b0;
    end
    else
    begin
      busy_a <= fire_a || (busy_a && !i_conv_done_set_a);
      busy_b <= fire_b || (busy_b && !i_conv_done_set_b);
      if (pre_b && busy_a)
        o_slot_b_sequence_fault <= 1'b1;
      else if (i_clear_fault_b)
        o_slot_b_sequence_fault <= 1'b0;
      if (pre_a && busy_b)
        o_slot_a_sequence_fault <= 1'b1;
      else if (i_clear_fault_a)
        o_slot_a_sequence_fault <= 1'b0;
    end
  end
  // converter wiring: pre-triggers onto the hardware selects
  assign o_out.conv_hw_select_a = pre_a;
  assign o_out.conv_hw_select_b = pre_b;
  assign o_out.slot_a_conv_start = fire_a;
  assign o_out.slot_b_conv_start = fire_b;

  // =====================================================================
  // checks
  property p_fault_b;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (pre_b && busy_a) |=> o_slot_b_sequence_fault;
  endproperty
  a_fault_b: assert property (p_fault_b) else $error("b fault not set");
  property p_fault_a;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (pre_a && busy_b) |=> o_slot_a_sequence_fault;
  endproperty
  a_fault_a: assert property (p_fault_a) else $error("a fault not set");
  property p_no_b_while_a;
    @(posedge i_mclk) disable iff (!i_reset_n)
      $past(busy_a) && busy_a |-> !fire_b;
  endproperty
  a_no_b_while_a: assert property (p_no_b_while_a) else $error("b fired in a");
  property p_no_a_while_b;
    @(posedge i_mclk) disable iff (!i_reset_n)
      $past(busy_b) && busy_b |-> !fire_a;
  endproperty
  a_no_a_while_b: assert property (p_no_a_while_b) else $error("a fired in b");
  property p_trig_after_pre;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (pre_a && !busy_b && i_cfg.slot_a_enable) |=> fire_a;
  endproperty
  a_trig_after_pre: assert property (p_trig_after_pre) else $error("trigger late");
  property p_enable_low;
    @(posedge i_mclk) disable iff (!i_reset_n)
      !i_cfg.slot_a_enable [*2] |-> !pre_a && !fire_a;
  endproperty
  a_enable_low: assert property (p_enable_low) else $error("disabled slot a active");
  property p_pre_lat;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (go_b && i_cfg.slot_b_enable) ##1 i_cfg.slot_b_enable |=> pre_b;
  endproperty
  a_pre_lat: assert property (p_pre_lat) else $error("pre b latency");
  property p_sticky;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (o_slot_a_sequence_fault && !i_clear_fault_a) |=> o_slot_a_sequence_fault;
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault a dropped");
endmodule : pdt_chan

/* File: src/pdt_delay_trigger.sv */
// programmable delay trigger: shared counter and per-channel triggers
`timescale 1ns/1ns
`include "pdt_params.svh"
module pdt_delay_trigger
  import pdt_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_block_enable,
  input wire logic i_continuous_run_bit,
  input wire logic [7:0] i_prescale,
  input wire logic [15:0] i_modulus,
  input wire logic i_start_input_event,
  input pdt_chan_cfg_t [1:0] i_chan_cfg,
  input wire logic [1:0] i_conv_done_set_a,
  input wire logic [1:0] i_conv_done_set_b,
  input wire logic [1:0] i_clear_fault_a,
  input wire logic [1:0] i_clear_fault_b,
  output pdt_chan_out_t [1:0] o_chan_out,
  output logic [1:0] o_slot_a_sequence_fault,
  output logic [1:0] o_slot_b_sequence_fault,
  output logic [15:0] o_count,
  output logic o_running,
  output logic o_sequence_error_irq
);
  pdt_state_t state;
  pdt_state_t next_state;
  logic [7:0] pre_cnt;
  logic [15:0] next_count;
  logic [7:0] next_pre_cnt;
  logic trig_sync;
  logic trig_prev;
  logic [1:0] done_a_sync;
  logic [1:0] done_b_sync;

  // =====================================================================
  // pin inputs pass two flops before use
  pdt_sync u_sync_trig (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_async(i_start_input_event),
    .o_sync(trig_sync)
  );
  genvar g;
  generate
    for (g = 0; g < `PDT_NUM_CHAN; g++)
    begin : g_done
      pdt_sync u_sync_a (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_async(i_conv_done_set_a[g]),
        .o_sync(done_a_sync[g])
      );
      pdt_sync u_sync_b (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_async(i_conv_done_set_b[g]),
        .o_sync(done_b_sync[g])
      );
    end
  endgenerate

  // =====================================================================
  // rising edge of the synchronised trigger is the start event
  wire trig_event = trig_sync && !trig_prev && i_block_enable;
  // prescaler tick on the last clock of each count value (0 and 1 mean every clock)
  wire tick = (i_prescale <= 8'h01) || (pre_cnt >= i_prescale - 8'h01);
  // first clock of each count value: delay compares are timed from here
  wire count_start = (pre_cnt == 8'h00);
  wire at_mod = (o_count == i_modulus) && tick;
  wire running = (state == PDT_RUN);

  // =====================================================================
  // counter state machine
  always_comb
  begin
    next_state = state;
    next_count = o_count;
    next_pre_cnt = pre_cnt;
    unique case (state)
      PDT_IDLE:
      begin
        if (trig_event)
        begin
          next_state = PDT_RUN;
          next_count = `PDT_CNT_RST;
          next_pre_cnt = `PDT_PRE_RST;
        end
      end
      PDT_RUN:
      begin
        if (trig_event)
        begin
          next_count = `PDT_CNT_RST; // retrigger restarts the count
          next_pre_cnt = `PDT_PRE_RST;
        end
        else if (at_mod)
        begin
          next_count = `PDT_CNT_RST;
          next_pre_cnt = `PDT_PRE_RST;
          if (!i_continuous_run_bit)
            next_state = PDT_IDLE;
        end
        else if (tick)
        begin
          next_count = o_count + 16'h0001;
          next_pre_cnt = `PDT_PRE_RST;
        end
        else
          next_pre_cnt = pre_cnt + 8'h01;
      end
      default:
        next_state = PDT_IDLE;
    endcase
    if (!i_block_enable)
    begin
      next_state = PDT_IDLE;
      next_count = `PDT_CNT_RST;
      next_pre_cnt = `PDT_PRE_RST;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state <= PDT_IDLE;
      o_count <= `PDT_CNT_RST;
      pre_cnt <= `PDT_PRE_RST;
      trig_prev <= 1'b0;
    end
    else
    begin
      state <= next_state;
      o_count <= next_count;
      pre_cnt <= next_pre_cnt;
      trig_prev <= trig_sync;
    end
  end
  assign o_running = running;

  // =====================================================================
  // channels, each comparing the shared count against its two delays
  generate
    for (g = 0; g < `PDT_NUM_CHAN; g++)
    begin : g_chan
      pdt_chan u_chan (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_enable(i_block_enable),
        .i_event(trig_event),
        .i_running(running),
        .i_tick(count_start),
        .i_count(o_count),
        .i_cfg(i_chan_cfg[g]),
        .i_conv_done_set_a(done_a_sync[g]),
        .i_conv_done_set_b(done_b_sync[g]),
        .i_clear_fault_a(i_clear_fault_a[g]),
        .i_clear_fault_b(i_clear_fault_b[g]),
        .o_out(o_chan_out[g]),
        .o_slot_a_sequence_fault(o_slot_a_sequence_fault[g]),
        .o_slot_b_sequence_fault(o_slot_b_sequence_fault[g])
      );
    end
  endgenerate

  // unmaskable error interrupt from any channel fault
  assign o_sequence_error_irq = |{o_slot_a_sequence_fault, o_slot_b_sequence_fault};

  // =====================================================================
  // checks
  property p_irq;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (|o_slot_a_sequence_fault) |-> o_sequence_error_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_wrap;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (running && at_mod && !trig_event && i_block_enable) |=> (o_count == 16'h0000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at modulus");
  property p_oneshot;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (running && at_mod && !trig_event && !i_continuous_run_bit) |=> !o_running;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot kept running");
  property p_disable;
    @(posedge i_mclk) disable iff (!i_reset_n)
      !i_block_enable |=> (o_count == 16'h0000) && !o_running;
  endproperty
  a_disable: assert property (p_disable) else $error("disabled counter moved");

  // =====================================================================
  // interrupt and counter checks
  property p_irq_b;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (|o_slot_b_sequence_fault) |-> o_sequence_error_irq;
  endproperty
  a_irq_b: assert property (p_irq_b) else $error("irq missing for b fault");
  property p_start;
    @(posedge i_mclk) disable iff (!i_reset_n)
      trig_event |=> o_running && (o_count == 16'h0000);
  endproperty
  a_start: assert property (p_start) else $error("count not started at zero");
  property p_step;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (running && tick && !at_mod && !trig_event && i_block_enable)
        |=> (o_count == $past(o_count) + 16'h0001);
  endproperty
  a_step: assert property (p_step) else $error("count did not step");
  property p_hold;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (running && !tick && !trig_event && i_block_enable) |=> $stable(o_count);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved between ticks");
  property p_idle_zero;
    @(posedge i_mclk) disable iff (!i_reset_n)
      !o_running |-> (o_count == 16'h0000);
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("stopped count not zero");
  property p_cont;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (running && at_mod && !trig_event && i_continuous_run_bit && i_block_enable)
        |=> o_running;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous count stopped");

  // =====================================================================
  // per-channel output checks
  generate
    for (g = 0; g < `PDT_NUM_CHAN; g++)
    begin : g_chk
      property p_pair_a;
        @(posedge i_mclk) disable iff (!i_reset_n)
          o_chan_out[g].slot_a_conv_start |-> $past(o_chan_out[g].conv_hw_select_a);
      endproperty
      a_pair_a: assert property (p_pair_a) else $error("start a without select");
      property p_pair_b;
        @(posedge i_mclk) disable iff (!i_reset_n)
          o_chan_out[g].slot_b_conv_start |-> $past(o_chan_out[g].conv_hw_select_b);
      endproperty
      a_pair_b: assert property (p_pair_b) else $error("start b without select");
      property p_off;
        @(posedge i_mclk) disable iff (!i_reset_n)
          !i_block_enable [*3] |=> (o_chan_out[g] == 4'h0);
      endproperty
      a_off: assert property (p_off) else $error("disabled block drove outputs");
      property p_bypass_a;
        @(posedge i_mclk) disable iff (!i_reset_n)
          (trig_event && i_chan_cfg[g].slot_a_enable
            && (i_chan_cfg[g].slot_a_output_select == `PDT_OS_BYPASS))
            ##1 i_chan_cfg[g].slot_a_enable |=> o_chan_out[g].conv_hw_select_a;
      endproperty
      a_bypass_a: assert property (p_bypass_a) else $error("bypass a late");
      property p_bypass_b;
        @(posedge i_mclk) disable iff (!i_reset_n)
          (trig_event && i_chan_cfg[g].slot_b_enable
            && (i_chan_cfg[g].slot_b_output_select == `PDT_OS_BYPASS))
            ##1 i_chan_cfg[g].slot_b_enable |=> o_chan_out[g].conv_hw_select_b;
      endproperty
      a_bypass_b: assert property (p_bypass_b) else $error("bypass b late");
      property p_seq_a;
        @(posedge i_mclk) disable iff (!i_reset_n)
          $rose(o_slot_a_sequence_fault[g])
            |-> $past(o_chan_out[g].conv_hw_select_a) && !o_chan_out[g].slot_a_conv_start;
      endproperty
      a_seq_a: assert property (p_seq_a) else $error("a fault without held start");
      property p_seq_b;
        @(posedge i_mclk) disable iff (!i_reset_n)
          $rose(o_slot_b_sequence_fault[g])
            |-> $past(o_chan_out[g].conv_hw_select_b) && !o_chan_out[g].slot_b_conv_start;
      endproperty
      a_seq_b: assert property (p_seq_b) else $error("b fault without held start");
      property p_clear_a;
        @(posedge i_mclk) disable iff (!i_reset_n)
          (i_clear_fault_a[g] && !o_chan_out[g].conv_hw_select_a)
            |=> !o_slot_a_sequence_fault[g];
      endproperty
      a_clear_a: assert property (p_clear_a) else $error("fault a not cleared");
      property p_clear_b;
        @(posedge i_mclk) disable iff (!i_reset_n)
          (i_clear_fault_b[g] && !o_chan_out[g].conv_hw_select_b)
            |=> !o_slot_b_sequence_fault[g];
      endproperty
      a_clear_b: assert property (p_clear_b) else $error("fault b not cleared");
      property p_sticky_b;
        @(posedge i_mclk) disable iff (!i_reset_n)
          (o_slot_b_sequence_fault[g] && !i_clear_fault_b[g]) |=> o_slot_b_sequence_fault[g];
      endproperty
      a_sticky_b: assert property (p_sticky_b) else $error("fault b dropped");
    end
  endgenerate
endmodule : pdt_delay_trigger

/* File: test/pdt_conv_model.sv */
// behavioural converter: ping-pong conversion slots answering trigger pulses
`timescale 1ns/1ns
module pdt_conv_model (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_preselect_a,
  input wire logic i_preselect_b,
  input wire logic i_start_a,
  input wire logic i_start_b,
  input wire logic [7:0] i_conv_len,
  output logic o_done_a,
  output logic o_done_b
);
  logic pre_a_d;
  logic pre_b_d;
  logic set_b;
  int left;
  int hold;
  // =====================================================================
  // conversion timer
  // a start only counts when its preselect stood the cycle before
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      {pre_a_d, pre_b_d, set_b, o_done_a, o_done_b} <= 5'h00;
      left <= 0;
      hold <= 0;
    end
    else
    begin
      pre_a_d <= i_preselect_a;
      pre_b_d <= i_preselect_b;
      if (hold > 0) hold <= hold - 1;
      else {o_done_a, o_done_b} <= 2'h0;
      if (left > 1) left <= left - 1;
      else if (left == 1)
      begin
        left <= 0;
        hold <= 4; // done level held long enough for the sync flops
        if (set_b) o_done_b <= 1'b1;
        else o_done_a <= 1'b1;
      end
      if (i_start_a && pre_a_d)
      begin
        left <= i_conv_len;
        set_b <= 1'b0;
        o_done_a <= 1'b0;
      end
      else if (i_start_b && pre_b_d)
      begin
        left <= i_conv_len;
        set_b <= 1'b1;
        o_done_b <= 1'b0;
      end
    end
  end
endmodule : pdt_conv_model

/* File: test/pdt_delay_trigger_bench.sv */
// self-checking bench for the programmable delay trigger
`timescale 1ns/1ns
`define PDT_CHK(nm, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      $display("MISMATCH %s exp %0h got %0h", nm, (exp), (got)); \
      bad_count++; \
    end \
  end
module pdt_delay_trigger_bench;
  import pdt_pkg::*;
  logic i_mclk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b1;
  logic cont = 1'b0;
  logic [7:0] pre = 8'h01;
  logic [15:0] modv = 16'h001e;
  logic ev = 1'b0;
  logic [7:0] conv_len = 8'h02;
  pdt_chan_cfg_t [1:0] cfg = '0;
  logic [1:0] done_a;
  logic [1:0] done_b;
  logic [1:0] clr_a = 2'h0;
  logic [1:0] clr_b = 2'h0;
  pdt_chan_out_t [1:0] o_chan_out;
  logic [1:0] fault_a;
  logic [1:0] fault_b;
  logic [15:0] o_count;
  logic o_running;
  logic irq;
  logic [3:0] obs [2];
  int n_hit [2][4];
  int t_hit [2][4];
  int cyc = 0;
  int bad_count = 0;
  int check_count = 0;
  // =====================================================================
  // clock, design and converter models
  initial forever #2 i_mclk = ~i_mclk;
  pdt_delay_trigger pdt_delay_trigger_i (
    .i_mclk(i_mclk), .i_reset_n(rst_n), .i_block_enable(en), .i_continuous_run_bit(cont),
    .i_prescale(pre), .i_modulus(modv), .i_start_input_event(ev), .i_chan_cfg(cfg),
    .i_conv_done_set_a(done_a), .i_conv_done_set_b(done_b), .i_clear_fault_a(clr_a),
    .i_clear_fault_b(clr_b), .o_chan_out(o_chan_out), .o_slot_a_sequence_fault(fault_a),
    .o_slot_b_sequence_fault(fault_b), .o_count(o_count), .o_running(o_running),
    .o_sequence_error_irq(irq));
  for (genvar c = 0; c < 2; c++)
  begin : g_conv
    // index 0 preselect a, 1 preselect b, 2 start a, 3 start b
    assign obs[c] = {o_chan_out[c].slot_b_conv_start, o_chan_out[c].slot_a_conv_start,
      o_chan_out[c].conv_hw_select_b, o_chan_out[c].conv_hw_select_a};
    pdt_conv_model pdt_conv_model_i (
      .i_mclk(i_mclk), .i_reset_n(rst_n), .i_preselect_a(obs[c][0]),
      .i_preselect_b(obs[c][1]), .i_start_a(obs[c][2]), .i_start_b(obs[c][3]),
      .i_conv_len(conv_len), .o_done_a(done_a[c]), .o_done_b(done_b[c]));
  end
  // =====================================================================
  // pulse monitor and hang guard
  always @(posedge i_mclk)
  begin
    for (int c = 0; c < 2; c++)
      for (int k = 0; k < 4; k++)
        if (obs[c][k] === 1'b1)
        begin
          if (n_hit[c][k] == 0) t_hit[c][k] = cyc;
          n_hit[c][k]++;
        end
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  // =====================================================================
  // helpers
  function automatic pdt_chan_cfg_t mk(input logic ea, input logic eb, input logic [1:0] oa,
                                       input logic [1:0] ob, input logic [15:0] da,
                                       input logic [15:0] db);
    return {ea, eb, oa, ob, da, db};
  endfunction : mk
  // load both channels, fire one start event, wait out the window
  task automatic run(input pdt_chan_cfg_t c0, input pdt_chan_cfg_t c1, input int win);
    @(posedge i_mclk);
    cfg <= {c1, c0};
    @(negedge i_mclk);
    n_hit = '{default: 0};
    @(posedge i_mclk);
    ev <= 1'b1;
    repeat (4) @(posedge i_mclk);
    ev <= 1'b0;
    repeat (win) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask : run
  // first slot converts slowly while the other slot's delay runs out
  task automatic fault(input logic b_first);
    run(mk(1, 1, 1, 1, b_first ? 16'h0008 : 16'h0002, b_first ? 16'h0002 : 16'h0008),
      mk(0, 0, 0, 0, 0, 0), 30);
    `PDT_CHK("late start", 0, n_hit[0][b_first ? 2 : 3]);
    `PDT_CHK("first start", 1, n_hit[0][b_first ? 3 : 2]);
    `PDT_CHK("fault a", {1'b0, b_first}, fault_a);
    `PDT_CHK("fault b", {1'b0, ~b_first}, fault_b);
    `PDT_CHK("irq", 1'b1, irq);
    repeat (30) @(posedge i_mclk);
    `PDT_CHK("sticky", {1'b0, 1'b1}, fault_a | fault_b);
    clr_a <= 2'h3;
    clr_b <= 2'h3;
    @(posedge i_mclk);
    {clr_a, clr_b} <= 4'h0;
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    `PDT_CHK("cleared", 4'h0, {fault_a, fault_b});
    `PDT_CHK("irq off", 1'b0, irq);
  endtask : fault
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // =====================================================================
  // main sequence
  initial
  begin
    repeat (12) @(posedge i_mclk);
    rst_n <= 1'b1;
    pre <= 8'h02;
    repeat (2) @(posedge i_mclk);
    // ch0 a bypassed with a decoy delay, b delayed; ch1 a delayed, b disabled
    run(mk(1, 1, 0, 1, 7, 5), mk(1, 0, 1, 1, 3, 9), 90);
    `PDT_CHK("delay a", 6, t_hit[1][0] - t_hit[0][0]);
    `PDT_CHK("delay b", 10, t_hit[0][1] - t_hit[0][0]);
    `PDT_CHK("trig a0", 1, t_hit[0][2] - t_hit[0][0]);
    `PDT_CHK("trig a1", 1, t_hit[1][2] - t_hit[1][0]);
    `PDT_CHK("trig b0", 1, t_hit[0][3] - t_hit[0][1]);
    `PDT_CHK("once", 1, n_hit[1][0]);
    `PDT_CHK("off b1", 0, n_hit[1][1] + n_hit[1][3]);
    for (int os = 2; os < 4; os++)
    begin
      run(mk(0, 0, 0, 0, 0, 0), mk(1, 0, os[1:0], 1, 3, 0), 90);
      `PDT_CHK("reserved os", 0, n_hit[1][0] + n_hit[1][2]);
    end
    @(posedge i_mclk);
    en <= 1'b0;
    run(mk(1, 1, 0, 1, 0, 2), mk(0, 0, 0, 0, 0, 0), 40);
    `PDT_CHK("disabled", 0, n_hit[0][0] + n_hit[0][1]);
    @(posedge i_mclk);
    en <= 1'b1;
    pre <= 8'h01;
    conv_len <= 8'h28;
    fault(1'b0);
    fault(1'b1);
    @(posedge i_mclk);
    conv_len <= 8'h02;
    modv <= 16'h0008;
    run(mk(1, 0, 1, 0, 3, 0), mk(0, 0, 0, 0, 0, 0), 30);
    `PDT_CHK("one shot", 17'h00000, {o_running, o_count});
    `PDT_CHK("one hit", 1, n_hit[0][0]);
    @(posedge i_mclk);
    cont <= 1'b1;
    run(mk(1, 0, 1, 0, 3, 0), mk(0, 0, 0, 0, 0, 0), 60);
    `PDT_CHK("cont run", 1'b1, o_running);
    `PDT_CHK("repeat", 1'b1, n_hit[0][0] >= 2);
    `PDT_CHK("wrap", 1'b1, o_count <= 16'h0008);
    @(posedge i_mclk);
    en <= 1'b0;
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    `PDT_CHK("en low", 17'h00000, {o_running, o_count});
    give_verdict();
  end
endmodule : pdt_delay_trigger_bench
